/* csc_pkg.sv */
// constants and types for the sequencer cascade coordinator
// Notes on behaviour
// (R1) idle fault line pin is monitored input
// (R2) own rail fault drives fault line low
// (R3) fault gone: release pin back to input
// (R4) line low from peer: run programmed response
// (R5) small variant: one fault line pin only
// (R6) slave powers on after master power good
// (R7) master drops power good when sequencing off
// (R8) slave fault: rails off, power good drops
// (R9) first device: returned good loss is undervoltage
// (R10) general input may replace monitor input
// (R11) ring only: all rails off together; the code turns them off one by one, last rail first
// (R12) rails depend on previous device power good
// (R13) upstream good loss raises undervoltage fault
// (R14) rails fully off output when all off
// (R15) downstream fully off gates sequencing off
// (R16) host disable: last device turns off first
// (R17) master shuts down after slaves fully off
// (R18) fault line gives no on/off ordering
// (R19) enabled general input low is a fault
// (R20) at most 14 restart attempts
// (R21) sync line, ignore own driven low
package csc_pkg;
   localparam int unsigned NRAIL = 4;
   localparam int unsigned NGPI  = 4;
   localparam int unsigned IDX_W = 2;
   localparam int unsigned CNT_W = 4;
   localparam int unsigned GAP_W = 10;

   localparam int unsigned CLK_PERIOD_NS  = 4;
   localparam int unsigned RESTART_GAP_NS = 2000;
   localparam logic [GAP_W-1:0] RESTART_GAP_CYC =
      GAP_W'((RESTART_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam logic [CNT_W-1:0] MAX_RESTARTS     = 4'hE;
   localparam logic [1:0]       RELEASE_MASK_CYC = 2'h3;

   localparam logic [CNT_W-1:0] RST_RESTARTS = 4'h0;
   localparam logic [NGPI-1:0]  RST_LINE     = 4'hF;
   localparam logic [IDX_W-1:0] LAST_RAIL    = IDX_W'(NRAIL - 1);

   typedef enum logic [3:0] {
      ST_OFF,
      ST_WAIT_DEP,
      ST_SEQ_ON,
      ST_ON,
      ST_WAIT_DOWN,
      ST_SEQ_OFF,
      ST_FAULT_OFF,
      ST_RESTART_GAP,
      ST_LOCKED
   } csc_state_e;

   typedef enum logic [1:0] {
      RESP_IGNORE,
      RESP_SHUTDOWN,
      RESP_RESTART_N,
      RESP_RESTART_CONT
   } csc_resp_e;
endpackage : csc_pkg

/* csc_sync.sv */
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none
module csc_sync #(
   parameter int unsigned W = 4
) (
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         // idle line is pulled high, so reset to high
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
            end else begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate
endmodule : csc_sync
`default_nettype wire

/* csc_seq_coord.sv */
// cascade coordination: fault line, power good chain and rails-off chain
`timescale 1ns/1ps
`default_nettype none
module csc_seq_coord (
   input  wire logic                         mclk,
   input  wire logic                         arst_n,
   input  wire logic                         power_en,
   input  wire logic                         is_master,
   input  wire logic                         ordered_off_en,
   input  wire logic                         small_variant,
   input  wire logic [csc_pkg::NGPI-1:0]     fline_sel,
   input  wire logic [csc_pkg::NGPI-1:0]     gpi_pin_i,
   output logic      [csc_pkg::NGPI-1:0]     gpi_pin_o,
   output logic      [csc_pkg::NGPI-1:0]     gpi_pin_oe,
   input  wire logic                         monitor_input,
   input  wire logic                         general_input_pin,
   input  wire logic                         dep_src_gpi,
   input  wire logic                         gpi_fault_en,
   input  wire logic                         downstream_off_in,
   input  wire csc_pkg::csc_resp_e           fault_resp,
   input  wire logic [csc_pkg::CNT_W-1:0]    restart_limit,
   input  wire logic [csc_pkg::NRAIL-1:0]    rail_fault,
   input  wire logic [csc_pkg::NRAIL-1:0]    rail_pg,
   input  wire logic [csc_pkg::NRAIL-1:0]    rail_off,
   output logic      [csc_pkg::NRAIL-1:0]    rail_en,
   output logic                              pg_logic_output_pin,
   output logic                              off_logic_output_pin,
   output logic                              undervoltage_fault,
   output logic                              fault_seen,
   output logic                              restarts_exhausted
);
   csc_pkg::csc_state_e             state_q;
   logic [csc_pkg::IDX_W-1:0]       idx_q;
   logic [csc_pkg::NRAIL-1:0]       rail_en_q;
   logic [csc_pkg::NGPI-1:0]        oe_q;
   logic [csc_pkg::NGPI-1:0]        line_sync;
   logic [csc_pkg::NGPI-1:0]        fline_low;
   logic [csc_pkg::NGPI-1:0]        fline_eff;
   logic [1:0]                      mask_cnt_q;
   logic [csc_pkg::CNT_W-1:0]       restart_cnt_q;
   logic [csc_pkg::CNT_W-1:0]       limit_eff;
   logic [csc_pkg::GAP_W-1:0]       gap_cnt_q;
   logic                            drive_q;
   logic                            drive_d;
   logic                            own_busy;
   logic                            line_low;
   logic                            peer_fault;
   logic                            dep_pg;
   logic                            armed_q;
   logic                            active;
   logic                            uv_d;
   logic                            gpi_fault;
   logic                            local_fault;
   logic                            any_fault;
   logic                            respond;
   logic                            leave_on;
   logic                            pg_q;
   logic                            off_q;
   logic                            uv_q;
   logic                            fault_seen_q;
   logic                            exhausted_q;

   // fault line pins pass the synchroniser before anything reads them
   // (R21) line synchroniser
   csc_sync #(
      .W (csc_pkg::NGPI)
   ) u_line_sync (
      .mclk   (mclk),
      .arst_n (arst_n),
      .d      (gpi_pin_i),
      .q      (line_sync)
   );

   // (R5) lowest selected pin only
   assign fline_low = fline_sel & (~fline_sel + {{(csc_pkg::NGPI-1){1'b0}}, 1'b1});
   assign fline_eff = small_variant ? fline_low : fline_sel;

   // (R12) dependency source select
   assign dep_pg = dep_src_gpi ? general_input_pin : monitor_input;

   assign active = (state_q == csc_pkg::ST_SEQ_ON) || (state_q == csc_pkg::ST_ON) ||
                   (state_q == csc_pkg::ST_WAIT_DOWN);

   // (R13) slave watches upstream good
   // (R9) master watches returned good once armed
   always_comb begin
      uv_d = 1'b0;
      if (is_master) begin
         uv_d = armed_q && (state_q == csc_pkg::ST_ON) && !dep_pg;
      end else begin
         uv_d = active && !dep_pg;
      end
   end

   // (R19) general input low is a fault
   // (R10) same path serves returned good
   assign gpi_fault = gpi_fault_en && !general_input_pin && active;

   assign local_fault = (|rail_fault) || uv_d || gpi_fault;

   // (R2) drive low while own fault stands
   assign drive_d = (|fline_eff) && local_fault;

   // released line reads low a few cycles more through the synchroniser
   // (R21) mask own driven low
   assign own_busy   = drive_q || (mask_cnt_q != 2'h0);
   assign line_low   = |(fline_eff & ~line_sync);
   assign peer_fault = line_low && !own_busy;

   assign any_fault = local_fault || peer_fault;

   // (R4) common response to any fault
   // (R18) fault only, no ordering from line
   assign respond = any_fault && (fault_resp != csc_pkg::RESP_IGNORE) &&
                    (active || (state_q == csc_pkg::ST_SEQ_OFF));

   // (R11) ring only: straight to sequencing off
   // (R15) wait for downstream fully off
   assign leave_on = (state_q == csc_pkg::ST_ON) && !power_en &&
                     !(ordered_off_en && !downstream_off_in);

   // (R20) clamp restart count
   assign limit_eff = (restart_limit > csc_pkg::MAX_RESTARTS) ? csc_pkg::MAX_RESTARTS
                                                             : restart_limit;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         drive_q <= 1'b0;
         oe_q    <= '0;
      end else begin
         // (R1) input while no own fault
         // (R3) release once cleared
         drive_q <= drive_d;
         oe_q    <= fline_eff & {csc_pkg::NGPI{drive_d}};
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mask_cnt_q <= 2'h0;
      end else if (drive_q) begin
         mask_cnt_q <= csc_pkg::RELEASE_MASK_CYC;
      end else if (mask_cnt_q != 2'h0) begin
         mask_cnt_q <= mask_cnt_q - 2'h1;
      end
   end

   // master arms only after the ring returned good once
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         armed_q <= 1'b0;
      end else if (state_q != csc_pkg::ST_ON) begin
         armed_q <= 1'b0;
      end else if (dep_pg) begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= csc_pkg::ST_OFF;
         idx_q   <= '0;
      end else begin
         unique case (state_q)
            csc_pkg::ST_OFF: begin
               if (power_en && !any_fault) begin
                  state_q <= csc_pkg::ST_WAIT_DEP;
               end
            end
            csc_pkg::ST_WAIT_DEP: begin
               if (!power_en) begin
                  state_q <= csc_pkg::ST_OFF;
               // (R6) slave waits for master good
               end else if (is_master || dep_pg) begin
                  state_q <= csc_pkg::ST_SEQ_ON;
                  idx_q   <= '0;
               end
            end
            csc_pkg::ST_SEQ_ON: begin
               if (respond) begin
                  state_q <= csc_pkg::ST_FAULT_OFF;
               end else if (!power_en) begin
                  state_q <= csc_pkg::ST_SEQ_OFF;
               end else if (rail_pg[idx_q]) begin
                  if (idx_q == csc_pkg::LAST_RAIL) begin
                     state_q <= csc_pkg::ST_ON;
                  end else begin
                     idx_q <= idx_q + 2'h1;
                  end
               end
            end
            csc_pkg::ST_ON: begin
               idx_q <= csc_pkg::LAST_RAIL;
               if (respond) begin
                  state_q <= csc_pkg::ST_FAULT_OFF;
               end else if (leave_on) begin
                  state_q <= csc_pkg::ST_SEQ_OFF;
               end else if (!power_en) begin
                  state_q <= csc_pkg::ST_WAIT_DOWN;
               end
            end
            // (R17) hold own rails until slaves off
            // (R16) last device has no wait, goes first
            csc_pkg::ST_WAIT_DOWN: begin
               if (respond) begin
                  state_q <= csc_pkg::ST_FAULT_OFF;
               end else if (downstream_off_in) begin
                  state_q <= csc_pkg::ST_SEQ_OFF;
               end
            end
            csc_pkg::ST_SEQ_OFF: begin
               if (respond) begin
                  state_q <= csc_pkg::ST_FAULT_OFF;
               end else if (rail_off[idx_q]) begin
                  if (idx_q == '0) begin
                     state_q <= csc_pkg::ST_OFF;
                  end else begin
                     idx_q <= idx_q - 2'h1;
                  end
               end
            end
            csc_pkg::ST_FAULT_OFF: begin
               if (!any_fault && (&rail_off)) begin
                  unique case (fault_resp)
                     csc_pkg::RESP_RESTART_N: begin
                        if (restart_cnt_q < limit_eff) begin
                           state_q <= csc_pkg::ST_RESTART_GAP;
                        end else begin
                           state_q <= csc_pkg::ST_LOCKED;
                        end
                     end
                     csc_pkg::RESP_RESTART_CONT: begin
                        state_q <= csc_pkg::ST_RESTART_GAP;
                     end
                     default: begin
                        state_q <= csc_pkg::ST_LOCKED;
                     end
                  endcase
               end
            end
            csc_pkg::ST_RESTART_GAP: begin
               if (any_fault) begin
                  state_q <= csc_pkg::ST_FAULT_OFF;
               end else if (!power_en) begin
                  state_q <= csc_pkg::ST_OFF;
               end else if (gap_cnt_q == csc_pkg::RESTART_GAP_CYC) begin
                  state_q <= csc_pkg::ST_WAIT_DEP;
               end
            end
            csc_pkg::ST_LOCKED: begin
               // a latched-off device only comes back through a host cycle
               if (!power_en) begin
                  state_q <= csc_pkg::ST_OFF;
               end
            end
            default: begin
               state_q <= csc_pkg::ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         gap_cnt_q <= '0;
      end else if (state_q == csc_pkg::ST_RESTART_GAP) begin
         gap_cnt_q <= gap_cnt_q + 10'h001;
      end else begin
         gap_cnt_q <= '0;
      end
   end

   // (R20) count restart attempts
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         restart_cnt_q <= csc_pkg::RST_RESTARTS;
         exhausted_q   <= 1'b0;
      end else if (state_q == csc_pkg::ST_OFF || state_q == csc_pkg::ST_ON) begin
         restart_cnt_q <= csc_pkg::RST_RESTARTS;
         exhausted_q   <= 1'b0;
      end else if (state_q == csc_pkg::ST_FAULT_OFF && !any_fault && (&rail_off) &&
                   fault_resp == csc_pkg::RESP_RESTART_N) begin
         if (restart_cnt_q < limit_eff) begin
            restart_cnt_q <= restart_cnt_q + 4'h1;
         end else begin
            exhausted_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rail_en_q <= '0;
      end else if (respond) begin
         // (R8) all own rails off at once
         rail_en_q <= '0;
      end else begin
         unique case (state_q)
            csc_pkg::ST_SEQ_ON:    rail_en_q[idx_q] <= 1'b1;
            csc_pkg::ST_SEQ_OFF:   rail_en_q[idx_q] <= 1'b0;
            csc_pkg::ST_ON,
            csc_pkg::ST_WAIT_DOWN: rail_en_q <= rail_en_q;
            default:               rail_en_q <= '0;
         endcase
      end
   end

   // (R7) good drops as soon as off begins
   // (R8) good drops on own fault
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pg_q <= 1'b0;
      end else begin
         pg_q <= (&rail_pg) && !respond &&
                 (((state_q == csc_pkg::ST_ON) && !leave_on) ||
                  ((state_q == csc_pkg::ST_WAIT_DOWN) && !downstream_off_in));
      end
   end

   // (R14) fully off only when every rail is off
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         off_q <= 1'b0;
      end else begin
         off_q <= !(|rail_en_q) && (&rail_off);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         uv_q         <= 1'b0;
         fault_seen_q <= 1'b0;
      end else begin
         uv_q         <= uv_d;
         fault_seen_q <= any_fault;
      end
   end

   assign gpi_pin_oe           = oe_q;
   // pin only ever drives low, so its data is tied low
   assign gpi_pin_o            = '0;
   assign rail_en              = rail_en_q;
   assign pg_logic_output_pin  = pg_q;
   assign off_logic_output_pin = off_q;
   assign undervoltage_fault   = uv_q;
   assign fault_seen           = fault_seen_q;
   assign restarts_exhausted   = exhausted_q;

   chk_idle_input: assert property (@(posedge mclk) disable iff (!arst_n) // R1
      !local_fault |=> (gpi_pin_oe == '0))
      else $error("fault pin driven without own fault");

   chk_fault_drive: assert property (@(posedge mclk) disable iff (!arst_n) // R2
      ((|fline_eff) && local_fault) |=> (gpi_pin_oe == $past(fline_eff)))
      else $error("fault pin not driven on own fault");

   chk_pin_release: assert property (@(posedge mclk) disable iff (!arst_n) // R3
      $fell(drive_q) |-> (gpi_pin_oe == '0) ##1 (mask_cnt_q == 2'h2))
      else $error("fault pin not released or mask wrong");

   chk_peer_response: assert property (@(posedge mclk) disable iff (!arst_n) // R4
      (peer_fault && state_q == csc_pkg::ST_ON && fault_resp != csc_pkg::RESP_IGNORE)
      |=> (state_q == csc_pkg::ST_FAULT_OFF) && (rail_en == '0))
      else $error("peer fault not answered");

   chk_single_pin: assert property (@(posedge mclk) disable iff (!arst_n) // R5
      small_variant |=> ($countones(gpi_pin_oe) <= 1))
      else $error("more than one fault pin on small variant");

   chk_slave_wait: assert property (@(posedge mclk) disable iff (!arst_n) // R6
      (state_q == csc_pkg::ST_WAIT_DEP && !is_master && !dep_pg)
      |=> (state_q != csc_pkg::ST_SEQ_ON))
      else $error("slave started before master good");

   chk_pg_drop: assert property (@(posedge mclk) disable iff (!arst_n) // R7
      leave_on |=> !pg_logic_output_pin ##1 (state_q != csc_pkg::ST_ON))
      else $error("power good held while sequencing off");

   chk_fault_off: assert property (@(posedge mclk) disable iff (!arst_n) // R8
      (state_q == csc_pkg::ST_FAULT_OFF) |-> (rail_en == '0) && !pg_logic_output_pin)
      else $error("rails or good left on in fault");

   chk_off_flag: assert property (@(posedge mclk) disable iff (!arst_n) // R14
      off_logic_output_pin |-> ($past(rail_en_q) == '0) && $past(&rail_off))
      else $error("fully off asserted with a rail on");

   chk_wait_slaves: assert property (@(posedge mclk) disable iff (!arst_n) // R17
      (state_q == csc_pkg::ST_WAIT_DOWN && !downstream_off_in)
      |=> (state_q inside {csc_pkg::ST_WAIT_DOWN, csc_pkg::ST_FAULT_OFF}))
      else $error("sequenced off before downstream off");

   chk_restart_cap: assert property (@(posedge mclk) disable iff (!arst_n) // R20
      restart_cnt_q <= csc_pkg::MAX_RESTARTS)
      else $error("restart count above limit");

   chk_own_mask: assert property (@(posedge mclk) disable iff (!arst_n) // R21
      $fell(drive_q) |-> !peer_fault [*3])
      else $error("own released drive seen as peer fault");
endmodule : csc_seq_coord
`default_nettype wire

/* csc_peer_model.sv */
// far side model: peer devices on the shared fault wire and the rails
`timescale 1ns/1ps
`default_nettype none
module csc_peer_model (
   input  wire logic                     mclk,
   input  wire logic                     arst_n,
   input  wire logic                     slow,
   input  wire logic [csc_pkg::NGPI-1:0] peer_low,
   input  wire logic [csc_pkg::NGPI-1:0] gpi_pin_o,
   input  wire logic [csc_pkg::NGPI-1:0] gpi_pin_oe,
   input  wire logic [csc_pkg::NRAIL-1:0] rail_en,
   output logic      [csc_pkg::NGPI-1:0] gpi_pin_i,
   output logic      [csc_pkg::NRAIL-1:0] rail_pg,
   output logic      [csc_pkg::NRAIL-1:0] rail_off
);
   logic [csc_pkg::NRAIL-1:0] dly_q [8];
   logic [csc_pkg::NRAIL-1:0] tap;
   assign gpi_pin_i = ~((gpi_pin_oe & ~gpi_pin_o) | peer_low);
   assign tap = slow ? dly_q[7] : dly_q[1];
   assign rail_pg = tap & rail_en;
   assign rail_off = ~tap & ~rail_en;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 8; i++) dly_q[i] <= 4'h0;
      end else begin
         dly_q[0] <= rail_en;
         for (int i = 1; i < 8; i++) dly_q[i] <= dly_q[i-1];
      end
   end
endmodule : csc_peer_model
`default_nettype wire

/* csc_seq_coord_tb.sv */
// self-checking bench for the cascade coordinator
`timescale 1ns/1ps
`default_nettype none
module csc_seq_coord_tb;
   logic mclk = 0, arst_n = 0, power_en = 0, is_master = 1, ordered_off_en = 0;
   logic small_variant = 0, monitor_input = 1, general_input_pin = 1, dep_src_gpi = 0;
   logic gpi_fault_en = 0, downstream_off_in = 1, slow = 0;
   logic [3:0] fline_sel = 4'h1, peer_low = 4'h0, restart_limit = 4'h1, rail_fault = 4'h0;
   logic [3:0] gpi_pin_i, gpi_pin_o, gpi_pin_oe, rail_pg, rail_off, rail_en;
   logic pg_logic_output_pin, off_logic_output_pin, undervoltage_fault, fault_seen;
   logic restarts_exhausted;
   csc_pkg::csc_resp_e fault_resp = csc_pkg::RESP_SHUTDOWN;
   int fails = 0, num_checks = 0, cyc = 0;

   csc_seq_coord dut (.mclk(mclk), .arst_n(arst_n), .power_en(power_en),
      .is_master(is_master), .ordered_off_en(ordered_off_en), .small_variant(small_variant),
      .fline_sel(fline_sel), .gpi_pin_i(gpi_pin_i), .gpi_pin_o(gpi_pin_o),
      .gpi_pin_oe(gpi_pin_oe), .monitor_input(monitor_input),
      .general_input_pin(general_input_pin), .dep_src_gpi(dep_src_gpi),
      .gpi_fault_en(gpi_fault_en), .downstream_off_in(downstream_off_in),
      .fault_resp(fault_resp), .restart_limit(restart_limit), .rail_fault(rail_fault),
      .rail_pg(rail_pg), .rail_off(rail_off), .rail_en(rail_en),
      .pg_logic_output_pin(pg_logic_output_pin), .off_logic_output_pin(off_logic_output_pin),
      .undervoltage_fault(undervoltage_fault), .fault_seen(fault_seen),
      .restarts_exhausted(restarts_exhausted));
   csc_peer_model peer (.mclk(mclk), .arst_n(arst_n), .slow(slow), .peer_low(peer_low),
      .gpi_pin_o(gpi_pin_o), .gpi_pin_oe(gpi_pin_oe), .rail_en(rail_en),
      .gpi_pin_i(gpi_pin_i), .rail_pg(rail_pg), .rail_off(rail_off));

   always #2 mclk = ~mclk;
   // restart run dominates: 14 gaps of 500 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   function automatic logic pick(input int s);
      case (s)
         0: return pg_logic_output_pin === 1'b1;
         1: return off_logic_output_pin === 1'b1;
         2: return restarts_exhausted === 1'b1;
         4: return rail_en[0] === 1'b1;
         default: return rail_en !== 4'hf;
      endcase
   endfunction : pick
   task automatic wait_on(input int s, input int n);
      for (int i = 0; i < n && !pick(s); i++) tick(1);
   endtask : wait_on
   task automatic reset_dut();
      arst_n = 0;
      {power_en, is_master, ordered_off_en, small_variant} = 4'h4;
      {monitor_input, general_input_pin, dep_src_gpi, gpi_fault_en} = 4'hc;
      {downstream_off_in, slow, fline_sel, peer_low, rail_fault} = 14'h2100;
      fault_resp = csc_pkg::RESP_SHUTDOWN;
      restart_limit = 4'h1;
      tick(8);
      arst_n = 1;
      tick(2);
   endtask : reset_dut
   task automatic power_up();
      power_en = 1;
      wait_on(0, 300);
   endtask : power_up

   task automatic t_power_on(input logic s);
      reset_dut();
      slow = s;
      check(off_logic_output_pin, 1, "off flag at rest");
      power_up();
      check(pg_logic_output_pin, 1, "power good missing");
      check(rail_en, 4'hf, "rails not on");
      check(gpi_pin_oe, 4'h0, "pin driven without fault");
      check(off_logic_output_pin, 0, "off flag while on");
   endtask : t_power_on
   task automatic t_own_fault(input logic [3:0] sel, input logic sm, input logic [3:0] exp);
      reset_dut();
      fline_sel = sel;
      small_variant = sm;
      power_up();
      rail_fault = 4'h2;
      tick(3);
      check(gpi_pin_oe, exp, "fault pin not driven");
      check(gpi_pin_o, 4'h0, "fault pin not low");
      check(rail_en, 4'h0, "rails on during fault");
      check(pg_logic_output_pin, 0, "good kept during fault");
      check(fault_seen, 1, "own fault not flagged");
      rail_fault = 4'h0;
      tick(3);
      check(gpi_pin_oe, 4'h0, "pin not released");
   endtask : t_own_fault
   task automatic t_peer_fault(input csc_pkg::csc_resp_e r, input logic [3:0] exp);
      reset_dut();
      fault_resp = r;
      power_up();
      peer_low = 4'h1;
      tick(6);
      check(rail_en, exp, "peer fault response");
      check(gpi_pin_oe, 4'h0, "peer fault driven back");
      check(fault_seen, 1, "peer fault not flagged");
      peer_low = 4'h0;
      tick(2);
   endtask : t_peer_fault
   task automatic t_dependency(input logic src);
      reset_dut();
      is_master = 0;
      {dep_src_gpi, gpi_fault_en} = {src, src};
      {monitor_input, general_input_pin} = 2'h0;
      power_en = 1;
      tick(30);
      check(rail_en, 4'h0, "slave on before good");
      if (src) general_input_pin = 1;
      else monitor_input = 1;
      wait_on(0, 300);
      check(rail_en, 4'hf, "slave not on");
      {monitor_input, general_input_pin} = 2'h0;
      // uv flag stands one cycle: leaving the active states ends it
      tick(1);
      check(undervoltage_fault, 1, "upstream loss not a fault");
      tick(5);
      check(rail_en, 4'h0, "rails kept after loss");
   endtask : t_dependency
   task automatic t_master_return();
      reset_dut();
      power_up();
      tick(4);
      monitor_input = 0;
      tick(1);
      check(undervoltage_fault, 1, "returned good loss");
      tick(5);
      check(rail_en, 4'h0, "master rails kept");
   endtask : t_master_return
   task automatic t_ring_off();
      reset_dut();
      power_up();
      downstream_off_in = 0;
      power_en = 0;
      tick(3);
      check(pg_logic_output_pin, 0, "good kept in shutdown");
      wait_on(1, 200);
      check(rail_en, 4'h0, "ring shutdown blocked");
   endtask : t_ring_off
   task automatic t_ordered_off();
      reset_dut();
      ordered_off_en = 1;
      power_up();
      downstream_off_in = 0;
      power_en = 0;
      tick(20);
      check(rail_en, 4'hf, "off before downstream");
      downstream_off_in = 1;
      wait_on(3, 50);
      check(rail_en, 4'h7, "last rail not first off");
      check(pg_logic_output_pin, 0, "good kept while off");
      wait_on(1, 200);
      check(rail_en, 4'h0, "rails left on");
      check(off_logic_output_pin, 1, "off flag missing");
   endtask : t_ordered_off
   task automatic t_restarts();
      int n;
      reset_dut();
      fault_resp = csc_pkg::RESP_RESTART_N;
      restart_limit = 4'hf;
      power_en = 1;
      n = 0;
      while (n < 20) begin
         // fault each attempt before it reaches on: reaching on clears the count
         for (int i = 0; i < 900 && !pick(4) && !pick(2); i++) tick(1);
         if (pick(2)) break;
         rail_fault = 4'h1;
         tick(3);
         rail_fault = 4'h0;
         n++;
      end
      check(4'(n - 1), 4'he, "restart count");
      tick(600);
      check(rail_en, 4'h0, "rail back after limit");
      check(restarts_exhausted, 1, "limit not flagged");
   endtask : t_restarts

   initial begin
      t_power_on(0);
      t_power_on(1);
      t_own_fault(4'h1, 0, 4'h1);
      t_own_fault(4'h6, 1, 4'h2);
      t_peer_fault(csc_pkg::RESP_IGNORE, 4'hf);
      t_peer_fault(csc_pkg::RESP_SHUTDOWN, 4'h0);
      t_dependency(0);
      t_dependency(1);
      t_master_return();
      t_ring_off();
      t_ordered_off();
      t_restarts();
      close_out();
   end
endmodule : csc_seq_coord_tb
`default_nettype wire
